// [dv/spi_far_slave.sv]
// Far-side serial slave model answering the core in master mode
`timescale 1ns/1ps
`default_nettype none
module spi_far_slave (
  // Serial lines
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Format and data
  input wire logic clk_pol,
  input wire logic clk_pha,
  input wire logic [15:0] tx,
  output logic [15:0] rx
);
  logic [15:0] sh;
  // Next bit out; refill with inverted bits so stale data never looks valid
  task automatic launch();
    miso = sh[15];
    sh = {sh[14:0], ~sh[15]};
  endtask
  // Phase zero shows its first bit before any clock edge
  always @(tx) begin
    sh = tx;
    if (!clk_pha) launch();
  end
  // Leading edge samples in phase zero, trailing edge in phase one
  always @(sck) begin
    if ((sck !== clk_pol) == !clk_pha) rx = {rx[14:0], mosi};
    else launch();
  end
endmodule // spi_far_slave
`default_nettype wire

// [dv/tb_spi_core.sv]
// Self-checking bench for the serial port core in master and slave modes
`timescale 1ns/1ps
`default_nettype none
module tb_spi_core;
  logic pclk, presetn, psel, penable, pwrite, ss_n_i;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq, far_miso;
  logic [15:0] far_tx, far_rx;
  logic ext_sck, ext_mosi;
  logic [32:0] note[$];
  spi_core_pkg::ctrl_type cfg;
  int fails, checks;
  // Pull-ups on the lines; open-drain drivers only pull low
  // A far master drives sck and mosi while the core is a slave; idle high as pulled up
  wire logic sck_w = sck_oe ? sck_o : ext_sck;
  wire logic mosi_w = mosi_oe ? mosi_o : ext_mosi;
  wire logic miso_w = miso_oe ? miso_o : far_miso;
  spi_core spi_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sck_i(sck_w), .sck_o, .sck_oe, .mosi_i(mosi_w),
    .mosi_o, .mosi_oe, .miso_i(miso_w), .miso_o, .miso_oe, .ss_n_i, .irq);
  spi_far_slave spi_far_slave_i (.sck(sck_w), .mosi(mosi_w), .miso(far_miso),
    .clk_pol(cfg.clock_polarity_sel), .clk_pha(cfg.clock_phase_sel), .tx(far_tx), .rx(far_rx));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checks++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One bus transfer; a read leaves its expected answer for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] want);
    int k;
    @(posedge pclk);
    if (!w) note.push_back(want);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      fails++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] want);
    apb(1'b0, a, 32'h0, want);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d}, 33'h0);
  endtask
  function automatic logic [15:0] rev(input logic [15:0] v, input logic sz);
    logic [15:0] r;
    r = 16'h0000;
    for (int k = 0; k < 16; k++) if (k < (sz ? 16 : 8)) r[k] = v[(sz ? 15 : 7) - k];
    return r;
  endfunction
  // Bounded wait for the request line
  task automatic wait_irq();
    int k;
    for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge pclk);
    if (k == 3000) begin
      fails++;
      wrap_up();
    end
  endtask
  // Every completed read is compared with the oldest note
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1) check({pslverr, prdata}, note.pop_front());
  initial begin
    logic [15:0] dm, dp, x, m, ds;
    logic coll;
    int bad;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ss_n_i = 1'b1;
    ext_sck = 1'b1;
    ext_mosi = 1'b1;
    presetn = 1'b0;
    far_tx = 16'h0;
    cfg = '0;
    void'($urandom(32'hBFE8B25B));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, reserved and unmapped places, read-only status
    rd(8'hE0, 33'h0_0000_0004);
    rd(8'hF0, 33'h0);
    rd(8'hE8, 33'h0);
    rd(8'h04, 33'h1_0000_0000);
    wr(8'hF0, 16'hFFFF);
    rd(8'hF0, 33'h0);
    // Every format, random divider, collisions and open drain mixed in
    for (int i = 0; i < 32; i++) begin
      cfg = {1'b1, 1'b1, i[4], 1'b1, i[0], i[1], i[2], i[3], 8'($urandom_range(4, 2))};
      dm = 16'($urandom);
      dp = 16'($urandom);
      m = cfg.size ? 16'hFFFF : 16'h00FF;
      x = cfg.size ? dp : dp >> 8;
      coll = (i == 5 || i == 26);
      wr(8'hE0, cfg);
      // Let the idle-level change settle before the far side loads
      @(posedge pclk);
      far_tx = dp;
      wr(8'hF8, dm & m);
      if (coll) wr(8'hF8, ~dm);
      wait_irq();
      rd(8'hE0, {17'h0, cfg});
      rd(8'hF0, {17'h0, 1'b1, coll, 14'h0});
      rd(8'hF8, {17'h0, cfg.lsb_first_select ? rev(x, cfg.size) : x});
      rd(8'hF0, 33'h0);
      check({17'h0, far_rx & m},
        {17'h0, cfg.lsb_first_select ? rev(dm, cfg.size) : dm & m});
    end
    // Slave mode, both phases: the bench plays a far master bit by bit
    ext_sck <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      wr(8'hE0, 16'hC004 | 16'(p << 10));
      ds = 16'($urandom) & 16'h00FF;
      dm = 16'($urandom) & 16'h00FF;
      wr(8'hF8, ds);
      ss_n_i <= 1'b0;
      // Writing while selected in phase zero must collide
      if (p == 0) wr(8'hF8, ~ds);
      x = 16'h0000;
      for (int b = 7; b >= 0; b--) begin
        if (p == 0) ext_mosi <= dm[b];
        repeat (3) @(posedge pclk);
        if (p == 0) x[b] = miso_w;
        ext_sck <= 1'b1;
        if (p == 1) ext_mosi <= dm[b];
        repeat (3) @(posedge pclk);
        if (p == 1) x[b] = miso_w;
        ext_sck <= 1'b0;
      end
      repeat (3) @(posedge pclk);
      if (p == 0) ss_n_i <= 1'b1;
      wait_irq();
      rd(8'hF0, {17'h0, 1'b1, ~p[0], 14'h0});
      rd(8'hF8, {17'h0, dm});
      check({17'h0, x}, {17'h0, ds});
      // Phase one keeps select low through the whole exchange
      ss_n_i <= 1'b1;
    end
    // Stopped divider keeps the clock idle until a foreign master selects us
    wr(8'hE0, 16'hD801);
    wr(8'hF8, 16'h00A5);
    bad = 0;
    repeat (40) begin
      @(posedge pclk);
      bad += (sck_w !== 1'b1);
    end
    check(33'(bad), 33'h0);
    ss_n_i <= 1'b0;
    repeat (3) @(posedge pclk);
    ss_n_i <= 1'b1;
    check({32'h0, irq}, 33'h1);
    wr(8'hE0, 16'hD801);
    rd(8'hE0, 33'h0_0000_8801);
    rd(8'hF0, 33'h0_0000_1000);
    wr(8'hE0, 16'hD801);
    rd(8'hF0, 33'h0);
    rd(8'hE0, 33'h0_0000_D801);
    wrap_up();
  end
endmodule // tb_spi_core
`default_nettype wire

// [hdl/spi_core.sv]
// Serial peripheral port core with APB registers, master divider and fault logic
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spi_core_map.svh"
module spi_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i,
  // Request line
  output logic irq
);
  spi_core_pkg::ctrl_type ctrl, next_ctrl;
  spi_core_pkg::mstate_type state, next_state;
  logic xfer_done_flag, next_xfer_done_flag;
  logic write_collision_flag, next_write_collision_flag;
  logic mode_fault_flag, next_mode_fault_flag;
  logic arm_f, next_arm_f;
  logic arm_m, next_arm_m;
  logic [15:0] sh, next_sh;
  logic [15:0] rxbuf, next_rxbuf;
  logic dout, next_dout;
  logic [5:0] edges, next_edges;
  logic sck_lvl, next_sck_lvl;
  logic [7:0] div_cnt, next_div_cnt;
  logic sck_prev, ss_prev, s_run, next_s_run;
  logic [31:0] next_prdata;

  // Bus decode; zero wait states, data registered in setup
  logic acc, wr, rd, aligned, hit_c, hit_s, hit_d, hit_g;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign aligned = (paddr[1:0] == 2'b00);
  assign hit_c = aligned & (paddr[7:2] == `CTRL_IDX);
  assign hit_s = aligned & (paddr[7:2] == `STAT_IDX);
  assign hit_d = aligned & (paddr[7:2] == `DATA_IDX);
  assign hit_g = aligned & (paddr[7:2] == `GAP_IDX);
  assign pready = 1'b1;
  assign pslverr = acc & ~(hit_c | hit_s | hit_d | hit_g);

  // Mode and timing terms
  logic mact, sact, baud_ok, tick, m_edge, s_edge, ev, smp, lnc;
  logic m_done, s_done, busy, mf, rxb, top, dwr, accept, s_first;
  logic [5:0] last, ev_no;
  logic [15:0] sh_in;
  assign mact = ctrl.master_select & ctrl.spi_enable_bit;
  assign sact = ~ctrl.master_select & ctrl.spi_enable_bit;
  assign last = ctrl.size ? `EDGES16 : `EDGES8;
  assign baud_ok = (ctrl.baud >= `BAUD_MIN);
  // Tick only in master mode, so the slave never sees the divider
  assign tick = (state == spi_core_pkg::RUN) & mact & baud_ok
    & (div_cnt == ctrl.baud - `DIV_ONE);
  assign m_edge = tick & (edges != last);
  assign s_edge = sact & ~ss_n_i & (sck_i != sck_prev);
  assign ev = m_edge | s_edge;
  // A phase one slave frame restarts the count, so stale edges never leak in
  assign s_first = s_edge & ctrl.clock_phase_sel & ~s_run;
  assign ev_no = s_first ? `EDGE_ONE : edges + `EDGE_ONE;
  // Phase zero samples odd edges, phase one samples even edges
  assign smp = ev & (ev_no[0] ^ ctrl.clock_phase_sel);
  assign lnc = ev & ~smp;
  // Phase zero master ends on the last edge, phase one one half later
  assign m_done = tick & (ctrl.clock_phase_sel ? (edges == last)
    : (ev_no == last));
  assign s_done = s_edge & (ev_no == last);
  assign busy = (state == spi_core_pkg::RUN)
    | (sact & (ctrl.clock_phase_sel ? s_run : ~ss_n_i));
  assign mf = mact & ~ss_n_i;
  assign rxb = ctrl.master_select ? miso_i : mosi_i;
  assign top = ctrl.lsb_first_select ? sh[0] : (ctrl.size ? sh[15] : sh[7]);
  assign dwr = wr & hit_d;
  assign accept = dwr & ~busy;

  // Shift in one received bit in the chosen order
  always_comb begin
    if (ctrl.lsb_first_select) begin
      sh_in = ctrl.size ? {rxb, sh[15:1]} : {8'h00, rxb, sh[7:1]};
    end else begin
      sh_in = {sh[14:0], rxb};
    end
  end

  // Next state of the whole core
  always_comb begin
    next_ctrl = ctrl;
    next_state = state;
    next_xfer_done_flag = xfer_done_flag;
    next_write_collision_flag = write_collision_flag;
    next_mode_fault_flag = mode_fault_flag;
    next_arm_f = arm_f;
    next_arm_m = arm_m;
    next_sh = sh;
    next_rxbuf = rxbuf;
    next_dout = dout;
    next_edges = edges;
    next_sck_lvl = sck_lvl;
    next_div_cnt = div_cnt;
    next_s_run = s_run;
    // Status reads arm the clearing sequences
    if (rd & hit_s) begin
      if (xfer_done_flag | write_collision_flag) begin
        next_arm_f = 1'b1;
      end
      if (mode_fault_flag) begin
        next_arm_m = 1'b1;
      end
    end
    // Data access completes the done and collision clear
    if (acc & hit_d & arm_f) begin
      next_arm_f = 1'b0;
      if (~pwrite | xfer_done_flag) begin
        next_xfer_done_flag = 1'b0;
        next_write_collision_flag = 1'b0;
      end
    end
    // Control write; enable and master stay clear while faulted
    if (wr & hit_c) begin
      next_ctrl = spi_core_pkg::ctrl_type'(pwdata[15:0]);
      if (mode_fault_flag & ~arm_m) begin
        next_ctrl.spi_enable_bit = ctrl.spi_enable_bit;
        next_ctrl.master_select = ctrl.master_select;
      end
      if (arm_m) begin
        next_mode_fault_flag = 1'b0;
        next_arm_m = 1'b0;
      end
    end
    // Divider reloads on terminal count
    if (state == spi_core_pkg::RUN) begin
      next_div_cnt = tick ? 8'h00 : div_cnt + `DIV_ONE;
    end
    // Slave frame framing
    if (sact & ~ctrl.clock_phase_sel & ss_prev & ~ss_n_i) begin
      next_edges = 6'h00;
      next_dout = top;
    end
    if (s_first) begin
      next_s_run = 1'b1;
    end
    // Edge actions, shared by master and slave
    if (ev) begin
      next_edges = ev_no;
    end
    if (m_edge) begin
      next_sck_lvl = ~sck_lvl;
    end
    if (smp) begin
      next_sh = sh_in;
    end
    if (lnc) begin
      next_dout = top;
    end
    // End of transfer
    if (m_done | s_done) begin
      next_xfer_done_flag = 1'b1;
      next_rxbuf = smp ? sh_in : sh;
      if (~ctrl.size) begin
        next_rxbuf[15:8] = 8'h00;
      end
      next_edges = 6'h00;
      next_s_run = 1'b0;
      next_state = spi_core_pkg::IDLE;
    end
    // Data writes load the shifter or collide
    if (accept) begin
      next_sh = pwdata[15:0];
      next_dout = ctrl.lsb_first_select ? pwdata[0] : (ctrl.size ? pwdata[15] : pwdata[7]);
      if (mact) begin
        next_state = spi_core_pkg::RUN;
        next_div_cnt = 8'h00;
        next_edges = 6'h00;
        next_sck_lvl = 1'b0;
      end
    end else if (dwr) begin
      next_write_collision_flag = 1'b1;
    end
    // Leaving master mode abandons a master transfer instead of clocking on
    if (~mact) begin
      next_state = spi_core_pkg::IDLE;
      next_sck_lvl = 1'b0;
    end
    // Mode fault wins over everything else
    if (mf) begin
      next_ctrl.master_select = 1'b0;
      next_ctrl.spi_enable_bit = 1'b0;
      next_mode_fault_flag = 1'b1;
      next_state = spi_core_pkg::IDLE;
      next_sck_lvl = 1'b0;
      next_edges = 6'h00;
    end
    // Leaving slave mode drops a dangling phase one frame
    if (~sact) begin
      next_s_run = 1'b0;
    end
  end

  // Core registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      state <= spi_core_pkg::IDLE;
      xfer_done_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      mode_fault_flag <= 1'b0;
      arm_f <= 1'b0;
      arm_m <= 1'b0;
      sh <= 16'h0000;
      rxbuf <= 16'h0000;
      dout <= 1'b0;
      edges <= 6'h00;
      sck_lvl <= 1'b0;
      div_cnt <= 8'h00;
      sck_prev <= 1'b0;
      ss_prev <= 1'b1;
      s_run <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      state <= next_state;
      xfer_done_flag <= next_xfer_done_flag;
      write_collision_flag <= next_write_collision_flag;
      mode_fault_flag <= next_mode_fault_flag;
      arm_f <= next_arm_f;
      arm_m <= next_arm_m;
      sh <= next_sh;
      rxbuf <= next_rxbuf;
      dout <= next_dout;
      edges <= next_edges;
      sck_lvl <= next_sck_lvl;
      div_cnt <= next_div_cnt;
      sck_prev <= sck_i;
      ss_prev <= ss_n_i;
      s_run <= next_s_run;
    end
  end

  // Read mux; data reads return the receive buffer, not the shifter
  always_comb begin
    next_prdata = 32'h00000000;
    if (psel & ~penable & ~pwrite) begin
      if (hit_c) begin
        next_prdata[15:0] = ctrl;
      end
      if (hit_s) begin
        next_prdata[`DONE_BIT] = xfer_done_flag;
        next_prdata[`COLL_BIT] = write_collision_flag;
        next_prdata[`FAULT_BIT] = mode_fault_flag;
      end
      if (hit_d) begin
        next_prdata[15:0] = rxbuf;
      end
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // Pads; open-drain drives only the low level, pull-up assumed
  logic sck_lv, mosi_drv, miso_drv;
  assign sck_lv = ctrl.clock_polarity_sel ^ sck_lvl;
  assign mosi_drv = mact;
  assign miso_drv = sact & ~ss_n_i;
  assign sck_o = ctrl.od ? 1'b0 : sck_lv;
  assign sck_oe = mact & (~ctrl.od | ~sck_lv);
  assign mosi_o = ctrl.od ? 1'b0 : dout;
  assign mosi_oe = mosi_drv & (~ctrl.od | ~dout);
  assign miso_o = ctrl.od ? 1'b0 : dout;
  assign miso_oe = miso_drv & (~ctrl.od | ~dout);
  // Fault clears master and enable, which releases sck and mosi
  assign irq = ctrl.irq_en & (xfer_done_flag | mode_fault_flag);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idle_sck_level: assert property (
    (state == spi_core_pkg::IDLE) |-> (sck_lv == ctrl.clock_polarity_sel))
    else $error("sck not at idle level");
  a_baud_stop: assert property (
    (mact && !baud_ok && !accept) |=> $stable(sck_lvl) && !tick)
    else $error("sck moved with divider below two");
  a_cpha0_first: assert property (
    (accept && mact && !ctrl.clock_phase_sel && baud_ok && !mf) |=> !sck_lvl [*2])
    else $error("sck active in first half of first cycle");
  a_collision_drop: assert property (
    (dwr && busy && !ev && !mf) |=> write_collision_flag && (sh == $past(sh)))
    else $error("colliding write reached shifter");
  a_master_done: assert property (
    m_done && !mf |=> xfer_done_flag && (state == spi_core_pkg::IDLE) && !sck_lvl)
    else $error("master end of transfer wrong");
  a_slave_done: assert property (
    s_done |=> xfer_done_flag && (edges == 6'h00))
    else $error("slave end of transfer wrong");
  a_fault_shut: assert property (
    mf |=> !ctrl.master_select && !ctrl.spi_enable_bit && mode_fault_flag
      && !sck_oe && !mosi_oe)
    else $error("mode fault did not shut down");
  a_fault_block: assert property (
    (mode_fault_flag && !arm_m) |=> !ctrl.spi_enable_bit && !ctrl.master_select)
    else $error("enable set while faulted");
  a_status_ro: assert property (
    (wr && hit_s && !m_done && !s_done && !mf && !dwr)
    |=> (xfer_done_flag == $past(xfer_done_flag))
      && (mode_fault_flag == $past(mode_fault_flag)))
    else $error("status changed by write");
  a_slave_nobaud: assert property (
    sact |-> !tick)
    else $error("divider ran in slave mode");

  c_master_xfer: cover property (accept && mact ##[1:1000] m_done);
  c_slave_xfer: cover property (s_done);
  c_collision: cover property (dwr && busy);
  c_fault: cover property (mf);
endmodule // spi_core
`default_nettype wire

// [hdl/spi_core_map.svh]
// Register indices, field positions, reset values and counts for the serial port core
`ifndef SPI_CORE_MAP_SVH
`define SPI_CORE_MAP_SVH
// Register indices; byte address is four times the index
`define CTRL_IDX 6'h38
`define GAP_IDX 6'h3A
`define STAT_IDX 6'h3C
`define DATA_IDX 6'h3E
// Status register bit positions
`define DONE_BIT 15
`define COLL_BIT 14
`define FAULT_BIT 12
// Control reset value, divider field of four
`define CTRL_RESET 16'h0004
`define BAUD_MIN 8'h02
// Edge counts per transfer
`define EDGES8 6'h10
`define EDGES16 6'h20
`define EDGE_ONE 6'h01
`define DIV_ONE 8'h01
`endif

// [hdl/spi_core_pkg.sv]
// Types shared by the serial port core
package spi_core_pkg;
  // Control register fields, bit 15 down to bit 0
  typedef struct packed {
    logic irq_en;
    logic spi_enable_bit;
    logic od;
    logic master_select;
    logic clock_polarity_sel;
    logic clock_phase_sel;
    logic lsb_first_select;
    logic size;
    logic [7:0] baud;
  } ctrl_type;
  typedef enum logic {IDLE, RUN} mstate_type;
endpackage
